// ---- common/rts_pkg.sv ----
// Shared constants for the remote temperature serial readout block
package rts_pkg;
   // Frame layout
   localparam int FRAME_BITS = 16;
   localparam int TEMP_BITS = 13;
   localparam int TEMP_MSB = 15;
   localparam int TEMP_LSB = 3;
   localparam int ZERO_BIT = 2;
   localparam int HIZ_BITS = 2;
   localparam logic [12:0] TEMP_RESET = 13'h0000;
   localparam logic [4:0] BIT_CNT_RESET = 5'h00;
   // Timing at 200 MHz clock
   localparam int CLK_MHZ = 200;
   localparam int CONV_TIME_MS = 320;
   localparam int PERIOD_FAST_MS = 500;
   localparam int PERIOD_SLOW_MS = 8000;
   localparam int CONV_CYCLES = CONV_TIME_MS * 1000 * CLK_MHZ;
   localparam int PERIOD_FAST_CYCLES = PERIOD_FAST_MS * 1000 * CLK_MHZ;
   localparam longint PERIOD_SLOW_CYCLES =
      longint'(PERIOD_SLOW_MS) * 1000 * CLK_MHZ;
   localparam int TIMER_W = 41;
   // Converter states
   typedef enum logic [1:0] {
      RTS_IDLE,
      RTS_CONVERT,
      RTS_WAIT
   } rts_conv_t;
endpackage

// ---- dv/rts_host.sv ----
// Serial master model reading frames from the readout
`timescale 1ns/1ps
module rts_host(
   input wire logic pin_in,
   input wire logic oe_in,
   output logic cs_n_out = 1'b1,
   output logic sck_out = 1'b0
);
   // Clock rests low between frames; a 16 ns high phase keeps the 48 ns
   // rate while the low phase covers the synchronised data update
   task automatic frame(input int n, output logic [15:0] w,
      output logic [15:0] e);
      w = 16'h0;
      e = 16'h0;
      cs_n_out <= 1'b0;
      #80;
      for (int i = 15; i > 15 - n; i--) begin
         sck_out <= 1'b1;
         w[i] = pin_in;
         e[i] = oe_in;
         #16 sck_out <= 1'b0;
         #32;
      end
      cs_n_out <= 1'b1;
   endtask
endmodule

// ---- dv/rts_readout_bench.sv ----
// Self-checking bench for the temperature serial readout
`timescale 1ns/1ps
module rts_readout_bench;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic [12:0] adc = 13'h0960;
   logic [12:0] res;
   logic [15:0] w, e;
   logic sdo, oe, conv, cs_n, sck;
   logic last_q = 1'b0;
   int n_errors = 0, tests_run = 0, cyc = 0, k = 0;
   // Rows: converter word in the top 13 bits, then the frame it reads as
   logic [28:0] rows [8] = '{29'h09604b00, 29'h07d03e80, 29'h01900c80,
      29'h00010008, 29'h0, 29'h1ffffff8, 29'h1e70f380, 29'h1c90e480};
   // A released pin shows the inverse of its last driven level
   wire pin = oe ? sdo : ~last_q;
   rts_readout #(.CONV_CYC(100), .FAST_CYC(300)) u_dut(.clock_in, .rst_in,
      .cs_n_in(cs_n), .sck_in(sck), .adc_temp_in(adc), .sdo_out(sdo),
      .sdo_oe_out(oe), .converting_out(conv), .result_out(res));
   rts_host u_host(.pin_in(pin), .oe_in(oe), .cs_n_out(cs_n), .sck_out(sck));
   initial forever #2.5 clock_in = ~clock_in;
   // Pin memory and run ceiling, far above the expected 3660 or so cycles
   always @(posedge clock_in) begin
      last_q <= oe ? sdo : last_q;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Undriven low bits are masked; their enables are checked instead
   task automatic rd(input logic [15:0] x);
      u_host.frame(16, w, e);
      @(posedge clock_in);
      check({w[15:2], 2'b00}, x);
      check(e, 16'hfffc);
   endtask
   initial begin
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
      check(res, 16'h0);
      check(oe, 1'b0);
      check(conv, 1'b1);
      foreach (rows[i]) begin
         adc <= rows[i][28:16];
         repeat (150) @(posedge clock_in);
         rd(rows[i][15:0]);
         check(res, rows[i][28:16]);
      end
      // A frame cutting a running conversion still reads the older word
      adc <= 13'h0abc;
      repeat (40) @(posedge clock_in);
      rd(16'he480);
      repeat (150) @(posedge clock_in);
      rd(16'h55e0);
      repeat (10) @(posedge clock_in);
      u_host.frame(5, w, e);
      check(w[15:11], 5'h0a);
      repeat (10) @(posedge clock_in);
      rd(16'h55e0);
      repeat (150) @(posedge clock_in);
      while (conv !== 1'b1 && k < 600) begin
         k++;
         @(posedge clock_in);
         #1;
      end
      check(conv, 1'b1);
      // Next start is one 300-clock period after the last one began
      check(16'(k > 145 && k < 165), 16'h1);
      @(posedge clock_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      check(res, 16'h0);
      rst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
      check(conv, 1'b1);
      check(oe, 1'b0);
      summarize();
   end
endmodule

// ---- dv/rts_readout_monitor.sv ----
// Port checker for the temperature serial readout
`timescale 1ns/1ps
module rts_readout_monitor(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic sdo_out,
   input wire logic sdo_oe_out,
   input wire logic converting_out,
   input wire logic [12:0] result_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // Pin edges reach the logic 3 to 6 clocks late through the synchroniser
   property p_load; $fell(cs_n_in) |-> ##[3:6] sdo_oe_out
      && sdo_out == result_out[12]; endproperty
   property p_halt; $fell(cs_n_in) |-> ##[3:6] !converting_out; endproperty
   property p_idle; (!cs_n_in) [*8] |-> !converting_out; endproperty
   property p_off; cs_n_in [*8] |-> !sdo_oe_out; endproperty
   property p_start; $rose(cs_n_in) |-> ##[3:6] converting_out; endproperty
   property p_keep; $changed(result_out) |-> $past(converting_out); endproperty
   property p_por; $fell(rst_in) |-> result_out == 13'h0 && !sdo_oe_out
      ##[0:2] converting_out; endproperty
   property p_rate; $fell(converting_out) ##1 cs_n_in [*8]
      |-> !converting_out; endproperty
   a_load: assert property (p_load) else $error("load");
   a_halt: assert property (p_halt) else $error("halt");
   a_idle: assert property (p_idle) else $error("idle");
   a_off: assert property (p_off) else $error("off");
   a_start: assert property (p_start) else $error("start");
   a_keep: assert property (p_keep) else $error("keep");
   a_por: assert property (p_por) else $error("por");
   a_rate: assert property (p_rate) else $error("rate");
   // Frames, finished conversions and aborted ones
   c_frame: cover property ($fell(cs_n_in));
   c_done: cover property ($fell(converting_out) && cs_n_in);
   c_cut: cover property ($fell(converting_out) && !cs_n_in);
endmodule
bind rts_readout rts_readout_monitor u_mon(.clock_in, .rst_in, .cs_n_in,
   .sdo_out, .sdo_oe_out, .converting_out, .result_out);

// ---- hw/rts_readout.sv ----
// Serial temperature readout and conversion control, device side
// Operation
// - Chip select falling copies last completed result into the shift register.
// - Data output changes on each serial clock falling edge, MSB first.
// - A frame is sixteen bit positions clocked while chip select is low.
// - Last two bit positions leave the data output undriven.
// - Chip select falling aborts a running conversion, result kept.
// - Chip select rising resets the interface and starts a new conversion.
// - Temperature sits in bits 15..3, two's complement; bit 2 is zero.
// - Conversions start automatically when power-on reset releases.
// - In reset the interface is idle and the stored result is zero.
// - With chip select low the converter idles; reads still work.
// - Undisturbed, conversions repeat at 0.5 s or 8 s period.
//
// Structure
// Both host pins pass the three-stage synchroniser, so every pin edge is
// acted on four to five clocks after it happens. At 200 MHz this is about
// 25 ns, well inside the 100 ns minimum clock phases the host may use.
// The converter is modelled by a timer: it samples the converter word
// once, on the last cycle of the conversion window, so a cut window
// never reaches the stored result.
// The repeat period is counted from the start of one conversion to the
// start of the next, which keeps the rate fixed whatever the window.
// The serial output is registered; its drive enable falls for the two
// final bit positions and whenever chip select is high.
`timescale 1ns/1ps
module rts_readout
   import rts_pkg::*;
#(
   parameter logic SLOW_VARIANT = 1'b0,
   parameter longint CONV_CYC = CONV_CYCLES,
   parameter longint FAST_CYC = PERIOD_FAST_CYCLES,
   parameter longint SLOW_CYC = PERIOD_SLOW_CYCLES
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic sck_in,
   input wire logic [12:0] adc_temp_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   output logic converting_out,
   output logic [12:0] result_out
);
   localparam logic [TIMER_W-1:0] CONV_T = TIMER_W'(CONV_CYC);
   localparam logic [TIMER_W-1:0] PERIOD_T =
      SLOW_VARIANT ? TIMER_W'(SLOW_CYC) : TIMER_W'(FAST_CYC);

   logic cs_n_s, sck_s;

   // Both pins come from the host's domain
   rts_sync u_cs_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .pin_in(cs_n_in),
      .reset_val_in(1'b1),
      .level_out(cs_n_s)
   );
   rts_sync u_sck_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .pin_in(sck_in),
      .reset_val_in(1'b1),
      .level_out(sck_s)
   );

   // Edge detection on the agreed levels
   logic cs_d_reg, sck_d_reg;
   logic cs_fall, cs_rise, sck_fall;
   assign cs_fall = cs_d_reg & ~cs_n_s;
   assign cs_rise = ~cs_d_reg & cs_n_s;
   assign sck_fall = sck_d_reg & ~sck_s;

   // Converter state
   rts_conv_t state_reg, state_next;
   logic [TIMER_W-1:0] timer_reg, timer_next;
   logic [12:0] temp_reg, temp_next;

   // Shifter state
   logic [FRAME_BITS-1:0] shift_reg, shift_next;
   logic [4:0] bit_reg, bit_next;
   logic sdo_reg, sdo_next;
   logic oe_reg, oe_next;
   logic conv_reg, conv_next;

   function automatic logic [FRAME_BITS-1:0] build_frame(
      input logic [12:0] t
   );
      logic [FRAME_BITS-1:0] f;
      f = '0;
      f[TEMP_MSB:TEMP_LSB] = t;
      f[ZERO_BIT] = 1'b0;
      return f;
   endfunction

   // Timer step; both timed states count the same way
   function automatic logic [TIMER_W-1:0] tick(
      input logic [TIMER_W-1:0] t
   );
      return t + TIMER_W'(1);
   endfunction

   // True on the last cycle of a window that is len cycles long
   function automatic logic at_end(
      input logic [TIMER_W-1:0] t,
      input logic [TIMER_W-1:0] len
   );
      return (t >= len - TIMER_W'(1));
   endfunction

   // Conversion sequencer: one measurement window, then wait for the period.
   // The timer runs on from the window into the wait, so the wait ends
   // one full period after the window began.
   // Chip select edges win over the timer: a fall parks the converter,
   // a rise restarts the window from zero.
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      temp_next = temp_reg;
      case (state_reg)
         RTS_IDLE: begin
            timer_next = '0;
         end
         RTS_CONVERT: begin
            timer_next = tick(timer_reg);
            if (at_end(timer_reg, CONV_T)) begin
               temp_next = adc_temp_in;
               state_next = RTS_WAIT;
            end
         end
         RTS_WAIT: begin
            timer_next = tick(timer_reg);
            if (at_end(timer_reg, PERIOD_T)) begin
               timer_next = '0;
               state_next = RTS_CONVERT;
            end
         end
         default: begin
            state_next = RTS_IDLE;
            timer_next = '0;
         end
      endcase
      // Abort leaves temp_reg untouched, so a cut result is never seen
      if (cs_fall) begin
         state_next = RTS_IDLE;
         timer_next = '0;
         temp_next = temp_reg;
      end else if (cs_rise) begin
         state_next = RTS_CONVERT;
         timer_next = '0;
      end
   end

   // Serial shifter; sck edges are seen up to four clocks late, fine for 5 MHz.
   // Chip select high holds the bit count and output cleared, so serial clock edges
   // outside a frame, including a false one after reset, do nothing.
   // Falls beyond the fifteenth are ignored: the frame has only sixteen
   // positions and the last ones are not driven anyway.
   always_comb begin
      shift_next = shift_reg;
      bit_next = bit_reg;
      sdo_next = sdo_reg;
      oe_next = oe_reg;
      if (cs_fall) begin
         shift_next = build_frame(temp_reg);
         bit_next = BIT_CNT_RESET;
         sdo_next = shift_next[FRAME_BITS-1];
         oe_next = 1'b1;
      end else if (cs_rise || cs_n_s) begin
         bit_next = BIT_CNT_RESET;
         oe_next = 1'b0;
         sdo_next = 1'b0;
      end else if (sck_fall && bit_reg < 5'(FRAME_BITS - 1)) begin
         shift_next = {shift_reg[FRAME_BITS-2:0], 1'b0};
         bit_next = bit_reg + 5'h01;
         sdo_next = shift_next[FRAME_BITS-1];
         // Positions for D1 and D0 float
         oe_next = (bit_next < 5'(FRAME_BITS - HIZ_BITS));
      end
      conv_next = (state_next == RTS_CONVERT);
   end

   // Registers; reset enters conversion so it starts on release.
   // The converting flag itself stays low in reset and rises on the first
   // clock after release, so nothing reads as busy while held.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cs_d_reg <= 1'b1;
         sck_d_reg <= 1'b1;
         state_reg <= RTS_CONVERT;
         timer_reg <= '0;
         temp_reg <= TEMP_RESET;
         shift_reg <= '0;
         bit_reg <= BIT_CNT_RESET;
         sdo_reg <= 1'b0;
         oe_reg <= 1'b0;
         conv_reg <= 1'b0;
      end else begin
         cs_d_reg <= cs_n_s;
         sck_d_reg <= sck_s;
         state_reg <= state_next;
         timer_reg <= timer_next;
         temp_reg <= temp_next;
         shift_reg <= shift_next;
         bit_reg <= bit_next;
         sdo_reg <= sdo_next;
         oe_reg <= oe_next;
         conv_reg <= conv_next;
      end
   end

   assign sdo_out = sdo_reg;
   assign sdo_oe_out = oe_reg;
   assign converting_out = conv_reg;
   assign result_out = temp_reg;
endmodule

// ---- hw/rts_sync.sv ----
// Three-stage pin synchroniser with agreement check on the last two stages
`timescale 1ns/1ps
module rts_sync
   import rts_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic pin_in,
   input wire logic reset_val_in,
   output logic level_out
);
   logic s1_reg, s2_reg, s3_reg, level_reg;
   logic s1_next, s2_next, s3_next, level_next;

   // Stage one is read by stage two only
   always_comb begin
      s1_next = pin_in;
      s2_next = s1_reg;
      s3_next = s2_reg;
      level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
   end

   // Reset values are constants; reset_val_in is a tie-off at elaboration
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         level_reg <= 1'b1;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;
endmodule
